// ---- hw/drc_pkg.sv ----
// Shared constants and types for the DAC readback and shutdown control pair.
// Assumes a two-wire bus with a master on the system clock and a slave on the bus clock.
package drc_pkg;
    localparam int DRC_BYTE_BITS = 8;
    localparam int DRC_WORD_BITS = 16;
    localparam int DRC_DATA_MAX = 12;
    localparam int DRC_DATA_MSB = 11;
    localparam int DRC_SEL_HI = 13;
    localparam int DRC_SEL_LO = 12;
    localparam logic [3:0] DRC_ACK_SLOT = 4'h8;
    localparam logic [3:0] DRC_LAST_BIT = 4'h7;
    localparam logic [5:0] DRC_ADDR6_FIXED = 6'h06;
    localparam logic [4:0] DRC_ADDR8_FIXED = 5'h03;
    localparam logic [1:0] DRC_SEL_NORMAL = 2'h0;
    localparam logic [1:0] DRC_SEL_PULL1K = 2'h1;
    localparam logic [1:0] DRC_SEL_PULL100K = 2'h2;
    localparam logic [1:0] DRC_SEL_OPEN = 2'h3;
    localparam logic [15:0] DRC_WORD_KEEP = 16'h3fff;
    localparam int DRC_CLK_NS = 40;
    localparam int DRC_RECOVER_5V_NS = 2500;
    localparam int DRC_RECOVER_3V_NS = 6000;
    localparam int DRC_RECOVER_5V_CYC = (DRC_RECOVER_5V_NS + DRC_CLK_NS - 1) / DRC_CLK_NS;
    localparam int DRC_RECOVER_3V_CYC = (DRC_RECOVER_3V_NS + DRC_CLK_NS - 1) / DRC_CLK_NS;
    localparam int DRC_SYS_KHZ = 25000;
    localparam int DRC_BUS_KHZ = 400;
    localparam int DRC_QUARTER_CYC = (DRC_SYS_KHZ + 4 * DRC_BUS_KHZ - 1) / (4 * DRC_BUS_KHZ);

    typedef enum logic [1:0] {LK_IDLE, LK_ADDR, LK_WRITE, LK_READ} drc_link_type;
    typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} drc_mst_type;

    typedef struct packed {
        drc_link_type phase;
        logic [3:0] bitCnt;
        logic [7:0] shiftIn;
        logic rw;
        logic byteHi;
        logic [7:0] hiByte;
        logic rdIdx;
        logic [7:0] txShift;
        logic [15:0] word;
        logic [15:0] wrWord;
        logic wrTog;
        logic startSeen;
        logic driveLow;
        logic [1:0] rstPipe;
        logic [1:0] strap0Pipe;
        logic [1:0] strap1Pipe;
    } drc_link_state_type;

    typedef struct packed {
        logic [2:0] wrSync;
        logic [1:0] forceSync;
        logic [11:0] code;
        logic [1:0] sel;
        logic [1:0] mode;
        logic ampOn;
        logic pull1k;
        logic pull100k;
        logic biasOn;
        logic [7:0] recoverCnt;
        logic valid;
    } drc_sys_state_type;

    typedef struct packed {
        drc_mst_type state;
        logic [7:0] divCnt;
        logic [1:0] quarter;
        logic [3:0] bitCnt;
        logic [1:0] byteCnt;
        logic [1:0] byteTotal;
        logic isRead;
        logic [7:0] txShift;
        logic [15:0] word;
        logic [7:0] rxShift;
        logic [15:0] rxWord;
        logic scl;
        logic sdaOeN;
        logic [1:0] sdaSync;
        logic ready;
        logic rdValid;
        logic nackErr;
    } drc_mst_state_type;
endpackage

// ---- hw/drc_bus_if.sv ----
// Two-wire bus between the master and the DAC slave.
// The data line is open drain: low when either side enables its driver.
`timescale 1ns/1ns
`default_nettype none
interface drc_bus_if;
    logic scl;
    logic sdaMstOeN;
    logic sdaDevOeN;
    logic sda;

    // Wired-AND with an implied pull-up
    assign sda = sdaMstOeN & sdaDevOeN;

    modport master (output scl, output sdaMstOeN, input sda);
    modport device (input scl, output sdaDevOeN, input sda);
endinterface
`default_nettype wire

// ---- hw/drc_dac_device.sv ----
// DAC slave: bus framing on the bus clock, DAC register and shutdown logic on clk_sys.
// Assumes the master keeps clocking the bus while sys_rst is high.
//
// Function
// [RQ1] Address byte first, then slave acknowledges low
// [RQ2] 8-bit variant returns one data byte
// [RQ3] Wider variants return two bytes with selector
// [RQ4] Selector taken from word bits 13, 12
// [RQ5] Selector codes map to four output modes
// [RQ6] Low force pin means open-output shutdown
// [RQ7] Unused force pin is held high
// [RQ8] Shutdown disconnects amplifier, bias and string; the code has no string control and clears only ampConnected and biasOn
// [RQ9] DAC register kept during shutdown
// [RQ10] Output valid only after recovery delay
// [RQ11] Strap pins give each slave distinct address
// [RQ12] Master releases data line outside writes
// [RQ13] Seven-bit address, fixed bits plus straps
// [RQ14] Word arrives MSB first, left-justified data
// [RQ15] Master ends read with no-ack, stop
// [RQ16] Every byte pair updates; repeated reads allowed
// [RQ17] Readback mirrors write layout, high first
// [RQ18] Code 00 with pin high resumes normal
`timescale 1ns/1ns
`default_nettype none
module drc_dac_device
    import drc_pkg::*;
#(
    parameter int DAC_BITS = 12,
    parameter int PIN_COUNT = 8,
    parameter bit SUPPLY_LOW = 1'b0
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    drc_bus_if.device bus,
    input wire logic shutdownForceN,
    input wire logic addrStrapBit0,
    input wire logic addrStrapBit1,
    output logic [DAC_BITS-1:0] dacCode,
    output logic [1:0] shutdownMode,
    output logic ampConnected,
    output logic pull1kOn,
    output logic pull100kOn,
    output logic biasOn,
    output logic outputValid
);
    localparam int RECOVER_CYC = SUPPLY_LOW ? DRC_RECOVER_3V_CYC : DRC_RECOVER_5V_CYC;
    localparam int PAD_BITS = DRC_DATA_MAX - DAC_BITS;
    localparam logic [15:0] KEEP_MASK = (DRC_WORD_KEEP >> PAD_BITS) << PAD_BITS;

    generate
        if (!(DAC_BITS == 8 || DAC_BITS == 10 || DAC_BITS == 12))
        begin : gBadBits
            $error("DAC_BITS must be 8, 10 or 12");
        end
        if (!(PIN_COUNT == 6 || PIN_COUNT == 8))
        begin : gBadPins
            $error("PIN_COUNT must be 6 or 8");
        end
        if (RECOVER_CYC > 255)
        begin : gBadRecover
            $error("Recovery count exceeds counter width");
        end
    endgenerate

    // Start detection: toggles on a data fall while the clock is high
    logic startTog;
    always_ff @(negedge bus.sda or posedge sys_rst)
    begin
        if (sys_rst)
            startTog <= 1'b0;
        else if (bus.scl)
            startTog <= ~startTog;
    end

    drc_link_state_type lq, ld;
    logic [6:0] ownAddr;
    logic [7:0] firstByte;
    logic [7:0] nextByte;
    logic sdaOeN_q;

    always_comb
    begin
        if (PIN_COUNT == 6)
            ownAddr = {DRC_ADDR6_FIXED, lq.strap0Pipe[1]}; // see [RQ13] see [RQ11]
        else
            ownAddr = {DRC_ADDR8_FIXED, lq.strap1Pipe[1], lq.strap0Pipe[1]}; // see [RQ13]
        // Readback bytes follow the write layout
        if (DAC_BITS == 8)
        begin
            firstByte = lq.word[DRC_DATA_MSB -: DRC_BYTE_BITS]; // see [RQ2]
            nextByte = firstByte;
        end
        else
        begin
            firstByte = lq.word[DRC_WORD_BITS-1 -: DRC_BYTE_BITS]; // see [RQ3] see [RQ17]
            nextByte = lq.rdIdx ? firstByte : lq.word[DRC_BYTE_BITS-1:0];
        end
    end

    always_comb
    begin
        ld = lq;
        ld.rstPipe = {lq.rstPipe[0], sys_rst};
        ld.strap0Pipe = {lq.strap0Pipe[0], addrStrapBit0};
        ld.strap1Pipe = {lq.strap1Pipe[0], addrStrapBit1};
        if (lq.rstPipe[1])
        begin
            ld.phase = LK_IDLE;
            ld.bitCnt = 4'h0;
            ld.shiftIn = 8'h00;
            ld.rw = 1'b0;
            ld.byteHi = 1'b0;
            ld.hiByte = 8'h00;
            ld.rdIdx = 1'b0;
            ld.txShift = 8'h00;
            ld.word = 16'h0000;
            ld.wrWord = 16'h0000;
            ld.wrTog = 1'b0;
            ld.startSeen = startTog;
            ld.driveLow = 1'b0;
        end
        else if (startTog != lq.startSeen)
        begin
            // First address bit follows every start or repeated start
            ld.startSeen = startTog;
            ld.phase = LK_ADDR; // see [RQ1]
            ld.bitCnt = 4'h1;
            ld.shiftIn = {7'h00, bus.sda};
            ld.driveLow = 1'b0;
            ld.byteHi = 1'b0;
        end
        else
        begin
            unique case (lq.phase)
                LK_IDLE:
                begin
                    ld.driveLow = 1'b0;
                end
                LK_ADDR:
                begin
                    if (lq.bitCnt == DRC_LAST_BIT)
                    begin
                        ld.rw = bus.sda;
                        ld.bitCnt = DRC_ACK_SLOT;
                        if (lq.shiftIn[6:0] == ownAddr)
                            ld.driveLow = 1'b1; // see [RQ1]
                        else
                            ld.phase = LK_IDLE; // see [RQ11]
                    end
                    else if (lq.bitCnt == DRC_ACK_SLOT)
                    begin
                        ld.bitCnt = 4'h0;
                        ld.rdIdx = 1'b0;
                        if (lq.rw)
                        begin
                            ld.phase = LK_READ;
                            ld.driveLow = ~firstByte[7];
                            ld.txShift = {firstByte[6:0], 1'b0};
                        end
                        else
                        begin
                            ld.phase = LK_WRITE;
                            ld.driveLow = 1'b0;
                        end
                    end
                    else
                    begin
                        ld.shiftIn = {lq.shiftIn[6:0], bus.sda};
                        ld.bitCnt = lq.bitCnt + 4'h1;
                    end
                end
                LK_WRITE:
                begin
                    if (lq.bitCnt == DRC_ACK_SLOT)
                    begin
                        ld.driveLow = 1'b0;
                        ld.bitCnt = 4'h0;
                        ld.byteHi = ~lq.byteHi;
                        if (!lq.byteHi)
                            ld.hiByte = lq.shiftIn;
                        else
                        begin
                            // Each completed pair updates the DAC
                            ld.word = {lq.hiByte, lq.shiftIn} & KEEP_MASK; // see [RQ14] see [RQ16]
                            ld.wrWord = ld.word;
                            ld.wrTog = ~lq.wrTog;
                        end
                    end
                    else
                    begin
                        ld.shiftIn = {lq.shiftIn[6:0], bus.sda}; // see [RQ14]
                        ld.bitCnt = lq.bitCnt + 4'h1;
                        ld.driveLow = (lq.bitCnt == DRC_LAST_BIT);
                    end
                end
                LK_READ:
                begin
                    if (lq.bitCnt == DRC_ACK_SLOT)
                    begin
                        if (!bus.sda)
                        begin
                            // Master acked: keep sending, wrapping for repeat reads
                            ld.bitCnt = 4'h0;
                            ld.rdIdx = ~lq.rdIdx; // see [RQ16]
                            ld.driveLow = ~nextByte[7];
                            ld.txShift = {nextByte[6:0], 1'b0};
                        end
                        else
                        begin
                            ld.phase = LK_IDLE; // see [RQ15]
                            ld.driveLow = 1'b0;
                        end
                    end
                    else
                    begin
                        ld.bitCnt = lq.bitCnt + 4'h1;
                        ld.driveLow = (lq.bitCnt == DRC_LAST_BIT) ? 1'b0 : ~lq.txShift[7];
                        ld.txShift = {lq.txShift[6:0], 1'b0};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge bus.scl or posedge sys_rst)
    begin
        if (sys_rst)
            lq <= '0;
        else
            lq <= ld;
    end

    // Data line changes only while the clock is low
    always_ff @(negedge bus.scl or posedge sys_rst)
    begin
        if (sys_rst)
            sdaOeN_q <= 1'b1;
        else if (lq.rstPipe[1])
            sdaOeN_q <= 1'b1;
        else
            sdaOeN_q <= ~lq.driveLow; // see [RQ12]
    end
    assign bus.sdaDevOeN = sdaOeN_q;

    // System side: DAC register and shutdown control
    drc_sys_state_type sq, sd;
    logic [1:0] effMode;
    logic downNow;

    always_comb
    begin
        sd = sq;
        sd.wrSync = {sq.wrSync[1:0], lq.wrTog};
        sd.forceSync = {sq.forceSync[0], shutdownForceN};
        if (sq.wrSync[2] != sq.wrSync[1])
        begin
            // Selector and code only change on a write or on sys_rst, never on shutdown
            sd.sel = lq.wrWord[DRC_SEL_HI:DRC_SEL_LO]; // see [RQ4]
            sd.code = lq.wrWord[DRC_DATA_MSB:0] >> PAD_BITS; // see [RQ9]
        end
        effMode = sq.forceSync[1] ? sd.sel : DRC_SEL_OPEN; // see [RQ6] see [RQ7] see [RQ18]
        downNow = (effMode != DRC_SEL_NORMAL);
        sd.mode = effMode;
        sd.ampOn = ~downNow; // see [RQ8]
        sd.biasOn = ~downNow; // see [RQ8]
        sd.pull1k = (effMode == DRC_SEL_PULL1K); // see [RQ5]
        sd.pull100k = (effMode == DRC_SEL_PULL100K); // see [RQ5]
        if (downNow)
        begin
            sd.recoverCnt = 8'h00;
            sd.valid = 1'b0;
        end
        else if (sq.recoverCnt != 8'(RECOVER_CYC))
        begin
            sd.recoverCnt = sq.recoverCnt + 8'h01; // see [RQ10]
            sd.valid = 1'b0;
        end
        else
            sd.valid = 1'b1; // see [RQ10]
        if (sys_rst)
        begin
            sd.code = 12'h000;
            sd.sel = DRC_SEL_NORMAL;
            sd.mode = DRC_SEL_NORMAL;
            sd.ampOn = 1'b1;
            sd.biasOn = 1'b1;
            sd.pull1k = 1'b0;
            sd.pull100k = 1'b0;
            sd.recoverCnt = 8'h00;
            sd.valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        sq <= sd;
    end

    assign dacCode = sq.code[DAC_BITS-1:0];
    assign shutdownMode = sq.mode;
    assign ampConnected = sq.ampOn;
    assign pull1kOn = sq.pull1k;
    assign pull100kOn = sq.pull100k;
    assign biasOn = sq.biasOn;
    assign outputValid = sq.valid;
endmodule // drc_dac_device
`default_nettype wire

// ---- hw/drc_bus_master.sv ----
// Bus master: makes the bus clock from clk_sys and runs one write or read per command.
// Assumes the data line is pulled up when nobody drives it.
`timescale 1ns/1ns
`default_nettype none
module drc_bus_master
    import drc_pkg::*;
#(
    parameter int QUARTER_CYC = DRC_QUARTER_CYC
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    drc_bus_if.master bus,
    input wire logic cmdValid,
    input wire logic cmdRead,
    input wire logic cmdTwoBytes,
    input wire logic [6:0] cmdAddr,
    input wire logic [15:0] cmdWord,
    output logic cmdReady,
    output logic rdValid,
    output logic [15:0] rdWord,
    output logic nackErr
);
    generate
        if (QUARTER_CYC < 3 || QUARTER_CYC > 256)
        begin : gBadDiv
            $error("QUARTER_CYC must be 3 to 256");
        end
    endgenerate

    drc_mst_state_type q, d;
    logic tick;
    logic sdaIn;
    logic mstSends;
    logic lastByte;

    always_comb
    begin
        d = q;
        d.sdaSync = {q.sdaSync[0], bus.sda};
        d.rdValid = 1'b0;
        sdaIn = q.sdaSync[1];
        tick = (q.divCnt == 8'(QUARTER_CYC - 1));
        mstSends = (q.byteCnt == 2'h0) || !q.isRead;
        lastByte = (q.byteCnt == q.byteTotal);
        d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
        if (tick)
            d.quarter = q.quarter + 2'h1;
        unique case (q.state)
            MS_IDLE:
            begin
                d.divCnt = 8'h00;
                d.quarter = 2'h0;
                d.scl = 1'b1;
                d.sdaOeN = 1'b1;
                d.ready = 1'b1;
                if (cmdValid)
                begin
                    d.ready = 1'b0;
                    d.nackErr = 1'b0;
                    d.isRead = cmdRead;
                    d.byteTotal = (cmdRead && !cmdTwoBytes) ? 2'h1 : 2'h2;
                    d.txShift = {cmdAddr, cmdRead}; // see [RQ1] see [RQ11]
                    d.word = cmdWord;
                    d.rxWord = 16'h0000;
                    d.bitCnt = 4'h0;
                    d.byteCnt = 2'h0;
                    d.state = MS_START;
                end
            end
            MS_START:
            begin
                if (tick && q.quarter == 2'h0)
                    d.sdaOeN = 1'b0;
                if (tick && q.quarter == 2'h3)
                begin
                    d.scl = 1'b0;
                    d.state = MS_BIT;
                end
            end
            MS_BIT:
            begin
                if (tick && q.quarter == 2'h0)
                begin
                    if (q.bitCnt != DRC_ACK_SLOT)
                        d.sdaOeN = mstSends ? q.txShift[7] : 1'b1; // see [RQ12]
                    else
                        d.sdaOeN = (mstSends || lastByte) ? 1'b1 : 1'b0; // see [RQ15] see [RQ12]
                end
                if (tick && q.quarter == 2'h1)
                    d.scl = 1'b1;
                if (tick && q.quarter == 2'h3)
                begin
                    d.scl = 1'b0;
                    if (q.bitCnt != DRC_ACK_SLOT)
                    begin
                        d.txShift = {q.txShift[6:0], 1'b0};
                        d.rxShift = {q.rxShift[6:0], sdaIn};
                        d.bitCnt = q.bitCnt + 4'h1;
                    end
                    else if (mstSends && sdaIn)
                    begin
                        d.nackErr = 1'b1;
                        d.state = MS_STOP;
                    end
                    else
                    begin
                        d.bitCnt = 4'h0;
                        d.byteCnt = q.byteCnt + 2'h1;
                        if (!mstSends)
                            d.rxWord = {q.rxWord[7:0], q.rxShift};
                        d.txShift = (q.byteCnt == 2'h0) ? q.word[15:8] : q.word[7:0];
                        if (lastByte)
                            d.state = MS_STOP;
                    end
                end
            end
            MS_STOP:
            begin
                if (tick && q.quarter == 2'h0)
                    d.sdaOeN = 1'b0;
                if (tick && q.quarter == 2'h1)
                    d.scl = 1'b1;
                if (tick && q.quarter == 2'h2)
                    d.sdaOeN = 1'b1;
                if (tick && q.quarter == 2'h3)
                begin
                    d.state = MS_IDLE;
                    d.rdValid = q.isRead && !q.nackErr;
                end
            end
        endcase
        if (sys_rst)
        begin
            d.state = MS_IDLE;
            d.divCnt = 8'h00;
            d.quarter = 2'h0;
            d.bitCnt = 4'h0;
            d.byteCnt = 2'h0;
            d.byteTotal = 2'h0;
            d.isRead = 1'b0;
            d.txShift = 8'h00;
            d.word = 16'h0000;
            d.rxShift = 8'h00;
            d.rxWord = 16'h0000;
            d.scl = 1'b1;
            d.sdaOeN = 1'b1;
            d.ready = 1'b0;
            d.rdValid = 1'b0;
            d.nackErr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        q <= d;
    end

    assign bus.scl = q.scl;
    assign bus.sdaMstOeN = q.sdaOeN;
    assign cmdReady = q.ready;
    assign rdValid = q.rdValid;
    assign rdWord = q.rxWord;
    assign nackErr = q.nackErr;
endmodule // drc_bus_master
`default_nettype wire

// ---- verif/drc_assertions.sv ----
// Concurrent checks on the DAC pair's bus data line and shutdown outputs.
// Assumes the bench instantiates it beside the bus interface.
`timescale 1ns/1ns
`default_nettype none
module drc_assertions
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sdaDevOeN,
    input wire logic shutdownForceN,
    input wire logic [1:0] shutdownMode,
    input wire logic ampConnected,
    input wire logic pull1kOn,
    input wire logic pull100kOn,
    input wire logic biasOn,
    input wire logic outputValid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_devChangeLow;
        $changed(sdaDevOeN) |-> !scl;
    endproperty
    a_devChangeLow: assert property (p_devChangeLow)
        else $error("device data moved with bus clock high");
    property p_devStable;
        scl [*2] |-> $stable(sdaDevOeN);
    endproperty
    a_devStable: assert property (p_devStable)
        else $error("device data unstable over clock high");
    property p_normal;
        shutdownMode == 2'h0 |-> ampConnected && biasOn && !pull1kOn && !pull100kOn;
    endproperty
    a_normal: assert property (p_normal)
        else $error("normal mode outputs wrong");
    property p_pull1k;
        shutdownMode == 2'h1 |-> pull1kOn && !pull100kOn && !ampConnected && !biasOn;
    endproperty
    a_pull1k: assert property (p_pull1k)
        else $error("1k shutdown outputs wrong");
    property p_pull100k;
        shutdownMode == 2'h2 |-> pull100kOn && !pull1kOn && !ampConnected && !biasOn;
    endproperty
    a_pull100k: assert property (p_pull100k)
        else $error("100k shutdown outputs wrong");
    property p_open;
        shutdownMode == 2'h3 |-> !(pull1kOn || pull100kOn || ampConnected || biasOn);
    endproperty
    a_open: assert property (p_open)
        else $error("open shutdown outputs wrong");
    property p_force;
        !shutdownForceN [*5] |-> shutdownMode == 2'h3;
    endproperty
    a_force: assert property (p_force)
        else $error("force pin did not open output");
    property p_validMode;
        shutdownMode != 2'h0 |-> !outputValid;
    endproperty
    a_validMode: assert property (p_validMode)
        else $error("output valid during shutdown");
    property p_recover;
        shutdownMode == 2'h0 && $past(shutdownMode) != 2'h0 |-> !outputValid [*8];
    endproperty
    a_recover: assert property (p_recover)
        else $error("output valid too soon after shutdown");
endmodule // drc_assertions
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench: bus master and DAC device joined by the bus interface.
// Assumes the master makes the bus clock from clk_sys.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [6:0] DEV_ADDR = 7'h0e;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b0;
    logic shutdownForceN = 1'b1;
    logic addrStrap0 = 1'b0;
    logic addrStrap1 = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic cmdTwoBytes = 1'b0;
    logic [6:0] cmdAddr = 7'h00;
    logic [15:0] cmdWord = 16'h0000;
    logic cmdReady, rdValid, nackErr, rdv;
    logic [15:0] rdWord;
    logic [11:0] dacCode;
    logic [1:0] shutdownMode;
    logic ampConnected, pull1kOn, pull100kOn, biasOn, outputValid;
    int n_errors = 0;
    int checked = 0;

    always #20 clk_sys = ~clk_sys;

    drc_bus_if i_drc_bus_if();
    drc_bus_master #(.QUARTER_CYC(4)) i_drc_bus_master (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .bus(i_drc_bus_if), .cmdValid(cmdValid), .cmdRead(cmdRead),
        .cmdTwoBytes(cmdTwoBytes), .cmdAddr(cmdAddr), .cmdWord(cmdWord),
        .cmdReady(cmdReady), .rdValid(rdValid), .rdWord(rdWord), .nackErr(nackErr));
    drc_dac_device #(.DAC_BITS(12), .PIN_COUNT(8), .SUPPLY_LOW(1'b0)) i_drc_dac_device (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(i_drc_bus_if),
        .shutdownForceN(shutdownForceN), .addrStrapBit0(addrStrap0),
        .addrStrapBit1(addrStrap1),
        .dacCode(dacCode), .shutdownMode(shutdownMode), .ampConnected(ampConnected),
        .pull1kOn(pull1kOn), .pull100kOn(pull100kOn), .biasOn(biasOn),
        .outputValid(outputValid));
    drc_assertions i_drc_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .scl(i_drc_bus_if.scl), .sdaDevOeN(i_drc_bus_if.sdaDevOeN),
        .shutdownForceN(shutdownForceN), .shutdownMode(shutdownMode),
        .ampConnected(ampConnected), .pull1kOn(pull1kOn), .pull100kOn(pull100kOn),
        .biasOn(biasOn), .outputValid(outputValid));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic waitReady();
        int k;
        k = 0;
        rdv = 1'b0;
        do
        begin
            @(posedge clk_sys);
            #1;
            k++;
            if (rdValid === 1'b1)
                rdv = 1'b1;
        end
        while (cmdReady !== 1'b1 && k < 3000);
        chk({15'h0000, cmdReady}, 16'h0001);
    endtask

    task automatic cmd(input logic rd, input logic two, input logic [6:0] a,
        input logic [15:0] w);
        waitReady();
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdRead <= rd;
        cmdTwoBytes <= two;
        cmdAddr <= a;
        cmdWord <= w;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        waitReady();
    endtask

    task automatic readChk(input logic two, input logic [15:0] exp);
        cmd(1'b1, two, DEV_ADDR, 16'h0000);
        chk({15'h0000, nackErr}, 16'h0000);
        chk({15'h0000, rdv}, 16'h0001);
        chk(rdWord, exp);
    endtask

    task automatic modeChk(input logic [1:0] m);
        chk({14'h0000, shutdownMode}, {14'h0000, m});
        chk({12'h000, ampConnected, biasOn, pull1kOn, pull100kOn},
            {12'h000, m == 2'h0, m == 2'h0, m == 2'h1, m == 2'h2});
    endtask

    task automatic recoverChk();
        chk({15'h0000, outputValid}, 16'h0000);
        repeat (90) @(posedge clk_sys);
        #1;
        chk({15'h0000, outputValid}, 16'h0001);
        modeChk(2'h0);
    endtask

    task automatic t_writeRead();
        chk({4'h0, dacCode}, 16'h0000);
        cmd(1'b0, 1'b1, DEV_ADDR, 16'hc5a3);
        chk({4'h0, dacCode}, 16'h05a3);
        modeChk(2'h0);
        readChk(1'b1, 16'h05a3);
        readChk(1'b0, 16'h0005);
        cmd(1'b0, 1'b1, DEV_ADDR, 16'h0a5c);
        chk({4'h0, dacCode}, 16'h0a5c);
    endtask

    task automatic t_modes();
        for (int m = 1; m < 4; m++)
        begin
            cmd(1'b0, 1'b1, DEV_ADDR, {2'b11, m[1:0], 12'h3c0 + 12'(m)});
            repeat (40) @(posedge clk_sys);
            #1;
            modeChk(m[1:0]);
            chk({4'h0, dacCode}, {4'h0, 12'h3c0 + 12'(m)});
            readChk(1'b1, {2'b00, m[1:0], 12'h3c0 + 12'(m)});
        end
        cmd(1'b0, 1'b1, DEV_ADDR, 16'h05a3);
        recoverChk();
    endtask

    task automatic t_force();
        @(posedge clk_sys);
        shutdownForceN <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        modeChk(2'h3);
        cmd(1'b0, 1'b1, DEV_ADDR, 16'h0123);
        modeChk(2'h3);
        chk({4'h0, dacCode}, 16'h0123);
        @(posedge clk_sys);
        shutdownForceN <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        recoverChk();
    endtask

    task automatic t_address();
        logic [6:0] bad [3] = '{7'h0c, 7'h0f, 7'h4e};
        for (int i = 0; i < 3; i++)
        begin
            cmd(1'b1, 1'b1, bad[i], 16'h0000);
            chk({15'h0000, nackErr}, 16'h0001);
        end
        readChk(1'b1, 16'h0123);
        // Strap change moves the slave to another address
        @(posedge clk_sys);
        addrStrap0 <= 1'b1;
        cmd(1'b1, 1'b1, DEV_ADDR, 16'h0000);
        chk({15'h0000, nackErr}, 16'h0001);
        cmd(1'b1, 1'b1, 7'h0f, 16'h0000);
        chk({15'h0000, nackErr}, 16'h0000);
        chk(rdWord, 16'h0123);
        @(posedge clk_sys);
        addrStrap0 <= 1'b0;
    endtask

    task automatic end_sim();
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_writeRead();
        t_modes();
        t_force();
        t_address();
        end_sim();
    end

    initial
    begin
        #(20000 * 40);
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        n_errors++;
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
